// ===== src/rgst_clk_div.sv
// Free-running even divider for the peripheral serial clock.
`timescale 1ns/10ps
module rgst_clk_div #(
    parameter int unsigned DIV = 10
) (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    output logic      sclk_out
);
    localparam int unsigned HALF = DIV / 2;
    localparam int unsigned CW   = $clog2(HALF + 1);
    localparam logic [CW-1:0] HALF_LAST = CW'(HALF - 1);

    logic [CW-1:0] cnt;

    // Toggle every half period, never gated.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt      <= '0;
            sclk_out <= 1'b0;
        end else if (cnt == HALF_LAST) begin
            cnt      <= '0;
            sclk_out <= !sclk_out;
        end else begin
            cnt      <= cnt + CW'(1);
        end
    end
endmodule : rgst_clk_div

// ===== src/rgst_io_decode.sv
// Address decoder of the processor I/O space.
`timescale 1ns/10ps
module rgst_io_decode
    import rgst_pkg::*;
(
    rgst_io_if.decoder bus
);
    logic io_act;
    logic uart_hit;

    // An access counts only while the I/O space and a strobe are active.
    assign io_act   = !bus.io_sel_n && (!bus.rd_n || !bus.wr_n);
    assign uart_hit = io_act && (bus.addr <= IO_UART_LAST);

    // UART select and strobes follow the processor strobes.
    assign bus.uart_sel_n = !uart_hit;
    assign bus.uart_rd_n  = !(uart_hit && !bus.rd_n);
    assign bus.uart_wr_n  = !(uart_hit && !bus.wr_n);

    // Timer, soft reset and board number gate decode.
    assign bus.timer_hit  = !bus.io_sel_n && !bus.wr_n && (bus.addr == IO_TIMER);
    assign bus.soft_rst   = io_act && (bus.addr == IO_SOFT_RST);
    assign bus.id_gate_n  = !(!bus.io_sel_n && !bus.rd_n && (bus.addr == IO_BOARD_ID));
endmodule : rgst_io_decode

// ===== src/rgst_io_if.sv
// Processor I/O bus and its decoded selects, between decoder and core.
`timescale 1ns/10ps
interface rgst_io_if;
    logic       io_sel_n;
    logic       rd_n;
    logic       wr_n;
    logic [4:0] addr;
    logic       uart_sel_n;
    logic       uart_rd_n;
    logic       uart_wr_n;
    logic       timer_hit;
    logic       soft_rst;
    logic       id_gate_n;

    modport decoder (input io_sel_n, rd_n, wr_n, addr,
                     output uart_sel_n, uart_rd_n, uart_wr_n, timer_hit, soft_rst, id_gate_n);
    modport core (output io_sel_n, rd_n, wr_n, addr,
                  input uart_sel_n, uart_rd_n, uart_wr_n, timer_hit, soft_rst, id_gate_n);
endinterface : rgst_io_if

// ===== src/rgst_pkg.sv
// Shared constants and types of the readout glue and sensor timer.
package rgst_pkg;

    // ********************************************************************
    // Processor I/O space map
    // ********************************************************************
    localparam int unsigned IO_ADDR_W     = 5;
    localparam logic [4:0]  IO_UART_LAST  = 5'h07;
    localparam logic [4:0]  IO_TIMER      = 5'h10;
    localparam logic [4:0]  IO_SOFT_RST   = 5'h11;
    localparam logic [4:0]  IO_BOARD_ID   = 5'h12;
    localparam logic        TIMER_START_D0 = 1'b0;

    // ********************************************************************
    // Clocking and link
    // ********************************************************************
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned SCLK_DIV      = 10;
    localparam logic [31:0] LINK_BAUD     = 32'h0001_c200;

    // ********************************************************************
    // Sensor timer geometry and pixel slot phases
    // ********************************************************************
    localparam int unsigned PIX_REAL      = 2048;
    localparam int unsigned PIX_DUMMY     = 39;
    localparam int unsigned PIX_TOTAL     = PIX_REAL + PIX_DUMMY;
    localparam int unsigned PIX_W         = 12;
    localparam int unsigned PHASE_W       = 4;
    localparam logic [3:0]  PH_FIRST      = 4'h0;
    localparam logic [3:0]  PH_RST_END    = 4'h3;
    localparam logic [3:0]  PH_BLACK_BEG  = 4'h4;
    localparam logic [3:0]  PH_CLK_END    = 4'h7;
    localparam logic [3:0]  PH_SIG_BEG    = 4'h8;
    localparam logic [3:0]  PH_SIG_END    = 4'hb;
    localparam logic [3:0]  PH_CONV_BEG   = 4'hc;
    localparam logic [3:0]  PH_LAST       = 4'hf;
    localparam logic [7:0]  GATE_LEN_RST  = 8'h28;

    // ********************************************************************
    // Wishbone register map (byte addresses)
    // ********************************************************************
    localparam logic [3:0]  WB_STATUS     = 4'h0;
    localparam logic [3:0]  WB_CONTROL    = 4'h4;
    localparam logic [3:0]  WB_INFO       = 4'h8;
    localparam int unsigned ST_BOARD_SEL  = 3;
    localparam int unsigned ST_HARD_RST   = 4;
    localparam int unsigned ST_PIX_LSB    = 16;

    // Timer states, one-hot.
    typedef enum logic [2:0] {
        T_IDLE = 3'b001,
        T_GATE = 3'b010,
        T_SCAN = 3'b100
    } rgst_state_t;

    // True when a slot phase lies inside an inclusive window.
    function automatic logic rgst_in_win(input logic [3:0] ph, input logic [3:0] lo, input logic [3:0] hi);
        return (ph >= lo) && (ph <= hi);
    endfunction : rgst_in_win

endpackage : rgst_pkg

// ===== src/rgst_top.sv
// Readout glue: I/O decode, signal steering, serial clock and sensor timer.
`timescale 1ns/10ps

// Notes on behaviour
// [R1] Serial clock is the system clock divided by ten, always running.
// [R2] I/O accesses decode from space select, strobes and address bits 0-4.
// [R3] Addresses 0-7 assert UART select with matching UART read or write.
// [R4] Write to address 16 starts the sensor timer sequence.
// [R5] Timer uses only data bit 0 of the write.
// [R6] Read at address 18 opens the board number gates.
// [R7] Processor reset on hard reset or on access to address 17.
// [R8] Processor reset output is the inverted OR of hard reset and soft reset.
// [R9] UART interrupt is passed inverted to the processor.
// [R10] Board selected flag is inverted to steer upstream transmit.
// [R11] Timer makes shift clock, reset, gate, captures, converter select, flag.
// [R12] Heartbeat loss asserts hard reset, resetting UART and processor.
// [R13] Upstream receive feeds UART and repeats unchanged downstream.
// [R14] Selected board sends UART data upstream, else downstream data.
// [R15] Link is fixed at 115200 bps, 8N1.
// [R16] Test mode and clock go downstream; test data out feeds next board.
// [R17] Processor reads board number after any reset.
// [R18] Writing zero to address 16 starts a conversion cycle.
// [R19] Timer goes idle, then gate with output gate, then scan.
// [R20] Each cycle has 2087 pixel slots: 2048 real, 39 dummy.
// [R21] After the last pixel the timer returns to idle.
// [R22] Selects act only with space select and strobe, never for unused addresses.
// [R23] Hard reset forces timer idle with sensor outputs inactive.
module rgst_top
    import rgst_pkg::*;
#(
    parameter int unsigned PIX_COUNT = PIX_TOTAL,
    parameter int unsigned DIV       = SCLK_DIV
) (
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        io_space_select_n_in,
    input  wire logic        read_strobe_n_in,
    input  wire logic        write_strobe_n_in,
    input  wire logic [4:0]  io_addr_in,
    input  wire logic        io_data0_in,
    output logic             uart_select_n_out,
    output logic             uart_read_n_out,
    output logic             uart_write_n_out,
    output logic             board_id_gate_n_out,
    input  wire logic        hard_reset_in,
    output logic             processor_reset_n_out,
    output logic             uart_reset_out,
    input  wire logic        uart_interrupt_in,
    output logic             uart_interrupt_n_out,
    input  wire logic        board_selected_in,
    output logic             board_selected_n_out,
    input  wire logic        upstream_rx_in,
    output logic             uart_rx_out,
    output logic             downstream_tx_out,
    input  wire logic        uart_tx_in,
    input  wire logic        downstream_rx_in,
    output logic             upstream_tx_out,
    input  wire logic        test_mode_in,
    input  wire logic        test_clock_in,
    input  wire logic        test_data_core_in,
    output logic             test_mode_out,
    output logic             test_clock_out,
    output logic             test_data_chain_out,
    output logic             serial_clock_out,
    output logic             sensor_shift_clock_n_out,
    output logic             sensor_reset_n_out,
    output logic             register_output_gate_n_out,
    output logic             black_level_capture_out,
    output logic             signal_capture_out,
    output logic             converter_select_n_out,
    output logic             transfer_start_flag_out,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out
);
    localparam logic [PIX_W-1:0] PIX_LAST = PIX_W'(PIX_COUNT - 1);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    rgst_io_if         io_bus ();
    rgst_state_t       state;
    rgst_state_t       next_state;
    logic [PHASE_W-1:0] phase;
    logic [PIX_W-1:0]  pixel;
    logic [7:0]        gate_cnt;
    logic [7:0]        gate_len;
    logic [7:0]        gate_len_eff;
    logic              timer_hit_q;
    logic              timer_start;
    logic              gate_done;
    logic              scan_done;
    logic              scanning;
    logic              wb_req;
    logic [31:0]       next_rdata;

    // ********************************************************************
    // I/O decode and serial clock
    // ********************************************************************
    // The decoder sees only the five low address bits. [R2]
    assign io_bus.io_sel_n = io_space_select_n_in;
    assign io_bus.rd_n     = read_strobe_n_in;
    assign io_bus.wr_n     = write_strobe_n_in;
    assign io_bus.addr     = io_addr_in;

    rgst_io_decode u_dec (
        .bus (io_bus.decoder)
    );

    // UART select and strobes, active only inside a real access. [R3] [R22]
    assign uart_select_n_out   = io_bus.uart_sel_n;
    assign uart_read_n_out     = io_bus.uart_rd_n;
    assign uart_write_n_out    = io_bus.uart_wr_n;
    // Board number gate for the read at its address. [R6]
    assign board_id_gate_n_out = io_bus.id_gate_n;

    // Peripheral serial clock, free running. [R1]
    rgst_clk_div #(
        .DIV (DIV)
    ) u_sclk (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .sclk_out (serial_clock_out)
    );

    // ********************************************************************
    // Reset, interrupt and link steering
    // ********************************************************************
    // Processor reset is low for hard reset or the soft reset access. [R7] [R8]
    assign processor_reset_n_out = !(hard_reset_in || io_bus.soft_rst);
    // A missed heartbeat raises hard reset, which also clears the UART. [R12]
    assign uart_reset_out        = hard_reset_in;
    // Interrupt and board flag are inverted on their way through. [R9]
    assign uart_interrupt_n_out  = !uart_interrupt_in;
    assign board_selected_n_out  = !board_selected_in; // [R10]

    // Receive data is repeated bit for bit; rate and framing are untouched. [R13] [R15]
    assign uart_rx_out       = upstream_rx_in;
    assign downstream_tx_out = upstream_rx_in;
    // Upstream source follows the board selection. [R14]
    assign upstream_tx_out   = board_selected_in ? uart_tx_in : downstream_rx_in;

    // Test access chain to the next board. [R16]
    assign test_mode_out       = test_mode_in;
    assign test_clock_out      = test_clock_in;
    assign test_data_chain_out = test_data_core_in;

    // ********************************************************************
    // Sensor timer
    // ********************************************************************
    // Start on the first cycle of a timer write carrying a zero bit 0. [R4] [R5] [R18]
    assign timer_start  = io_bus.timer_hit && !timer_hit_q && (io_data0_in == TIMER_START_D0);
    assign gate_len_eff = (gate_len == 8'h00) ? 8'h01 : gate_len;
    assign gate_done    = (gate_cnt == gate_len_eff - 8'h01);
    // The cycle ends at the last phase of the last dummy pixel. [R20]
    assign scan_done    = (phase == PH_LAST) && (pixel == PIX_LAST);
    assign scanning     = (state == T_SCAN);

    // Access edge detector for the timer write.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            timer_hit_q <= 1'b0;
        end else begin
            timer_hit_q <= io_bus.timer_hit;
        end
    end

    // Idle, gate, scan sequence; hard reset overrides everything. [R19] [R21] [R23]
    always_comb begin
        next_state = state;
        case (state)
            T_IDLE: begin
                if (timer_start) begin
                    next_state = T_GATE;
                end
            end
            T_GATE: begin
                if (gate_done) begin
                    next_state = T_SCAN;
                end
            end
            T_SCAN: begin
                if (scan_done) begin
                    next_state = T_IDLE;
                end
            end
            default: begin
                next_state = T_IDLE;
            end
        endcase
        if (hard_reset_in) begin
            next_state = T_IDLE;
        end
    end

    // State register.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= T_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Gate length counter, cleared outside the gate state.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gate_cnt <= 8'h00;
        end else if (state == T_GATE && next_state == T_GATE) begin
            gate_cnt <= gate_cnt + 8'h01;
        end else begin
            gate_cnt <= 8'h00;
        end
    end

    // Slot phase and pixel counters run only while scanning. [R20]
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            phase <= PH_FIRST;
            pixel <= '0;
        end else if (!scanning || hard_reset_in) begin
            phase <= PH_FIRST;
            pixel <= '0;
        end else begin
            phase <= phase + PHASE_W'(1);
            if (phase == PH_LAST) begin
                pixel <= scan_done ? '0 : pixel + PIX_W'(1);
            end
        end
    end

    // Sensor, capture and converter controls from state and phase. [R11] [R23]
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            register_output_gate_n_out <= 1'b1;
            sensor_shift_clock_n_out   <= 1'b1;
            sensor_reset_n_out         <= 1'b1;
            black_level_capture_out    <= 1'b0;
            signal_capture_out         <= 1'b0;
            converter_select_n_out     <= 1'b1;
            transfer_start_flag_out    <= 1'b0;
        end else begin
            register_output_gate_n_out <= !(next_state == T_GATE);
            sensor_shift_clock_n_out   <= !(scanning && !hard_reset_in && rgst_in_win(phase, PH_FIRST, PH_CLK_END));
            sensor_reset_n_out         <= !(scanning && !hard_reset_in && rgst_in_win(phase, PH_FIRST, PH_RST_END));
            black_level_capture_out    <= scanning && !hard_reset_in && rgst_in_win(phase, PH_BLACK_BEG, PH_CLK_END);
            signal_capture_out         <= scanning && !hard_reset_in && rgst_in_win(phase, PH_SIG_BEG, PH_SIG_END);
            converter_select_n_out     <= !(scanning && !hard_reset_in && rgst_in_win(phase, PH_CONV_BEG, PH_LAST));
            transfer_start_flag_out    <= scanning && !hard_reset_in && (phase == PH_CONV_BEG);
        end
    end

    // ********************************************************************
    // Wishbone slave
    // ********************************************************************
    assign wb_req = wb_cyc_in && wb_stb_in;

    // Read mux; unmapped offsets read as zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_in)
            WB_STATUS: begin
                next_rdata[2:0]                        = state;
                next_rdata[ST_BOARD_SEL]               = board_selected_in;
                next_rdata[ST_HARD_RST]                = hard_reset_in;
                next_rdata[ST_PIX_LSB +: PIX_W]        = pixel;
            end
            WB_CONTROL: begin
                next_rdata[7:0] = gate_len;
            end
            WB_INFO: begin
                next_rdata = LINK_BAUD; // [R15]
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Single-wait acknowledge with registered read data.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= wb_req && !wb_ack_out;
            if (wb_req && !wb_ack_out) begin
                wb_dat_out <= next_rdata;
            end
        end
    end

    // Gate length register, written at the acknowledging edge.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gate_len <= GATE_LEN_RST;
        end else if (wb_req && wb_we_in && wb_ack_out && wb_adr_in == WB_CONTROL && wb_sel_in[0]) begin
            gate_len <= wb_dat_in[7:0];
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking chk_cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    chk_sclk_period: assert property ($rose(serial_clock_out) |-> ##10 $rose(serial_clock_out)) // [R1]
        else $error("Serial clock period is not ten cycles");
    chk_uart_decode: assert property (!uart_select_n_out |-> !io_space_select_n_in && io_addr_in <= IO_UART_LAST
                                      && (uart_read_n_out == read_strobe_n_in)) // [R3]
        else $error("UART select outside its address range");
    chk_idle_quiet: assert property (io_space_select_n_in |-> uart_select_n_out && board_id_gate_n_out
                                     && processor_reset_n_out == !hard_reset_in) // [R22]
        else $error("Decoded select active without space select");
    chk_id_gate: assert property (!board_id_gate_n_out |-> io_addr_in == IO_BOARD_ID && !read_strobe_n_in) // [R6]
        else $error("Board number gate opened by a wrong access");
    chk_soft_reset: assert property (hard_reset_in || (!io_space_select_n_in && io_addr_in == IO_SOFT_RST // [R7]
                                     && !(read_strobe_n_in && write_strobe_n_in)) |-> !processor_reset_n_out)
        else $error("Hard reset not reaching the processor");
    chk_start_gate: assert property (state == T_IDLE && timer_start && !hard_reset_in
                                     |=> state == T_GATE ##0 !register_output_gate_n_out) // [R18]
        else $error("Timer start did not enter the gate state");
    chk_gate_scan: assert property (state == T_GATE && gate_done && !hard_reset_in |=> scanning ##1
                                    register_output_gate_n_out) // [R19]
        else $error("Gate state not followed by scan");
    chk_scan_end: assert property (scanning && scan_done && !hard_reset_in |=> state == T_IDLE && pixel == '0) // [R21]
        else $error("Timer not idle after the last pixel");
    chk_pixel_bound: assert property (scanning |-> pixel <= PIX_LAST) // [R20]
        else $error("Pixel count beyond the last slot");
    chk_flag_phase: assert property (transfer_start_flag_out |-> $past(phase) == PH_CONV_BEG
                                     ##1 !transfer_start_flag_out) // [R11]
        else $error("Transfer flag at a wrong phase");
    chk_hard_force: assert property (hard_reset_in |=> state == T_IDLE && converter_select_n_out
                                     && sensor_shift_clock_n_out && !transfer_start_flag_out) // [R23]
        else $error("Timer outputs active under hard reset");
    chk_link_route: assert property (board_selected_n_out |-> upstream_tx_out == downstream_rx_in) // [R14]
        else $error("Upstream source does not follow selection");
    chk_wb_ack: assert property (wb_req && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
        else $error("Bus acknowledge not a single cycle");

    cov_start: cover property (state == T_IDLE ##1 state == T_GATE);
    cov_full_scan: cover property (scanning && scan_done ##1 state == T_IDLE);
    cov_wb_write: cover property (wb_req && wb_we_in && wb_ack_out && wb_adr_in == WB_CONTROL);
    cov_soft_reset: cover property (io_bus.soft_rst && !hard_reset_in);

endmodule : rgst_top

// ===== tb/rgst_proc_model.sv
// Processor model driving the parallel I/O bus of the glue logic.
`timescale 1ns/10ps
module rgst_proc_model (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       act_in,
    input  wire logic       we_in,
    input  wire logic [4:0] addr_in,
    input  wire logic       d0_in,
    output logic            sel_n_out,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic [4:0]      addr_out,
    output logic            d0_out
);
    // Launches an access just after an edge; released lines show inverted data.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {sel_n_out, rd_n_out, wr_n_out, addr_out, d0_out} <= 9'h1c0;
        end else begin
            sel_n_out <= !act_in;
            rd_n_out  <= !(act_in && !we_in);
            wr_n_out  <= !(act_in && we_in);
            addr_out  <= act_in ? addr_in : ~addr_out;
            d0_out    <= act_in ? d0_in : ~d0_out;
        end
    end
endmodule : rgst_proc_model

// ===== tb/tb.sv
// Self-checking bench of the readout glue and sensor timer.
`timescale 1ns/10ps
module tb;
    import rgst_pkg::*;
    localparam int unsigned NPIX = 4;
    logic clk_in = 0, nrst_in, io_space_select_n_in, read_strobe_n_in, write_strobe_n_in, io_data0_in, p;
    logic hard_reset_in = 0, uart_interrupt_in = 0, board_selected_in = 0, upstream_rx_in = 0, uart_tx_in = 0;
    logic downstream_rx_in = 0, test_mode_in = 0, test_clock_in = 0, test_data_core_in = 0;
    logic pact = 0, pwe = 0, pd0 = 1, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, wb_ack_out;
    logic uart_select_n_out, uart_read_n_out, uart_write_n_out, board_id_gate_n_out, processor_reset_n_out;
    logic uart_reset_out, uart_interrupt_n_out, board_selected_n_out, uart_rx_out, downstream_tx_out;
    logic upstream_tx_out, test_mode_out, test_clock_out, test_data_chain_out, serial_clock_out;
    logic sensor_shift_clock_n_out, sensor_reset_n_out, register_output_gate_n_out, black_level_capture_out;
    logic signal_capture_out, converter_select_n_out, transfer_start_flag_out;
    logic [4:0]  io_addr_in, pa = 0;
    logic [3:0]  wb_adr_in = 0, wb_sel_in = 4'hf;
    logic [31:0] wb_dat_in = 0, wb_dat_out, q;
    int          n_errors = 0, compares = 0, cyc_cnt = 0, n, k;

    rgst_top #(.PIX_COUNT(NPIX)) rgst_top_inst (.*);
    rgst_proc_model rgst_proc_model_inst (.clk_in(clk_in), .nrst_in(nrst_in), .act_in(pact), .we_in(pwe),
        .addr_in(pa), .d0_in(pd0), .sel_n_out(io_space_select_n_in), .rd_n_out(read_strobe_n_in),
        .wr_n_out(write_strobe_n_in), .addr_out(io_addr_in), .d0_out(io_data0_in));

    // Clock, and a cycle ceiling that cuts a hang short.
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 4000) begin
            n_errors++;
            print_verdict();
        end
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %0t got %h want %h", $time, s, e);
        end
    endtask : chk

    task print_verdict;
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    // Classic single Wishbone cycle, held until ack is sampled.
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'h3, w, a, d};
        do @(posedge clk_in); while (wb_ack_out !== 1'b1);
        q = wb_dat_out;
        {wb_cyc_in, wb_stb_in} <= 2'h0;
    endtask : wb

    // Inversions and pass-through paths for every combination of the five link inputs.
    task t_wires;
        for (n = 0; n < 32; n++) begin
            @(posedge clk_in);
            {uart_interrupt_in, board_selected_in, upstream_rx_in, uart_tx_in, downstream_rx_in} <= n[4:0];
            {test_mode_in, test_clock_in, test_data_core_in, hard_reset_in} <= n[3:0];
            #1 chk({uart_interrupt_n_out, board_selected_n_out, uart_rx_out, downstream_tx_out, upstream_tx_out,
                test_mode_out, test_clock_out, test_data_chain_out, processor_reset_n_out, uart_reset_out},
                {~n[4], ~n[3], n[2], n[2], n[3] ? n[1] : n[0], n[3:1], ~n[0], n[0]});
        end
        @(posedge clk_in);
        hard_reset_in <= 0;
    endtask : t_wires

    // Every address read and written; selects drop when the access ends.
    task t_decode;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_in);
            {pwe, pa, pact} <= {n[5:0], 1'h1};
            repeat (2) @(posedge clk_in);
            #1 chk({uart_select_n_out, uart_read_n_out, uart_write_n_out, board_id_gate_n_out, processor_reset_n_out},
                {n[4:3] != 0, n[4:3] != 0 || n[5], n[4:3] != 0 || !n[5], n[5:0] != 18, n[4:0] != 17});
            @(posedge clk_in);
            pact <= 0;
            repeat (2) @(posedge clk_in);
            #1 chk({uart_select_n_out, uart_read_n_out, uart_write_n_out, board_id_gate_n_out}, 4'hf);
        end
    endtask : t_decode

    // Start a sequence and wait for the output gate.
    task start;
        @(posedge clk_in);
        {pa, pwe, pd0, pact} <= {IO_TIMER, 1'h1, TIMER_START_D0, 1'h1};
        for (k = 0; k < 9 && register_output_gate_n_out !== 1'b0; k++) @(posedge clk_in);
        pact <= 0;
    endtask : start

    // Gate length, pixel count, idle return, then hard reset in mid-sequence.
    task t_timer;
        wb(1, WB_CONTROL, 3);
        wb(0, WB_STATUS, 0);
        chk(q[2:0], 3'h1);
        start();
        for (n = 0; n < 20 && register_output_gate_n_out === 1'b0; n++) @(posedge clk_in);
        chk(n, 3);
        {n, k} = 0;
        repeat (NPIX * 16 + 4) begin
            @(posedge clk_in);
            n += transfer_start_flag_out;
            k += !sensor_shift_clock_n_out + black_level_capture_out + signal_capture_out + !converter_select_n_out
                + !sensor_reset_n_out;
        end
        chk(n, NPIX);
        chk(k, NPIX * 24);
        wb(0, WB_STATUS, 0);
        chk(q[2:0], 3'h1);
        start();
        repeat (4) @(posedge clk_in);
        hard_reset_in <= 1;
        repeat (2) @(posedge clk_in);
        #1 chk({register_output_gate_n_out, sensor_shift_clock_n_out, sensor_reset_n_out, converter_select_n_out,
            transfer_start_flag_out, processor_reset_n_out}, 6'h3c);
        @(posedge clk_in);
        hard_reset_in <= 0;
    endtask : t_timer

    // Fixed link rate, unmapped read, free-running serial clock.
    task t_misc;
        wb(0, WB_INFO, 0);
        chk(q, LINK_BAUD);
        wb(0, 4'hc, 0);
        chk(q, 0);
        k = 0;
        p = serial_clock_out;
        repeat (100) begin
            @(posedge clk_in);
            k += (serial_clock_out === 1'b1 && p === 1'b0);
            p = serial_clock_out;
        end
        chk(k, 100 / SCLK_DIV);
    endtask : t_misc

    initial begin
        nrst_in <= 0;
        repeat (20) @(posedge clk_in);
        nrst_in <= 1;
        t_wires();
        t_decode();
        t_timer();
        t_misc();
        print_verdict();
    end
endmodule : tb
